// ---- hw/pcfg_defs.svh ----
// Constants of the configuration header: offsets, fields, fixed values
`ifndef PCFG_DEFS_SVH
`define PCFG_DEFS_SVH
// ==========================================
// Register offsets (byte addresses)
`define PCFG_OFF_ID    8'h00
`define PCFG_OFF_CMD   8'h04
`define PCFG_OFF_CLASS 8'h08
`define PCFG_OFF_MISC  8'h0C
`define PCFG_OFF_IO    8'h10
`define PCFG_OFF_MEM   8'h14
`define PCFG_OFF_SUB   8'h2C
`define PCFG_OFF_ROM   8'h30
`define PCFG_OFF_CAP   8'h34
`define PCFG_OFF_INT   8'h3C
// ==========================================
// Command and status bit positions
`define PCFG_CMD_IO    0
`define PCFG_CMD_MEM   1
`define PCFG_CMD_BM    2
`define PCFG_CMD_PERR  6
`define PCFG_CMD_SERR  8
`define PCFG_STS_CAP   20
`define PCFG_STS_MDPE  24
`define PCFG_STS_STA   27
`define PCFG_STS_RTA   28
`define PCFG_STS_RMA   29
`define PCFG_STS_SSE   30
`define PCFG_STS_DPE   31
// ==========================================
// Fixed values and reset values
`define PCFG_DEVSEL_MED 2'h1
`define PCFG_CLASS      24'h020000
`define PCFG_HDR_SINGLE 8'h00
`define PCFG_HDR_MULTI  8'h80
`define PCFG_MAX_LAT    8'h28
`define PCFG_MIN_GNT    8'h14
`define PCFG_INT_PIN    8'h01
`define PCFG_CAP_PTR    8'h50
`define PCFG_RST_CMDEN  1'h1
`define PCFG_BAR_LSB    7
`define PCFG_ROM_LSB    18
`define PCFG_EE_SSVID   6'h00
`define PCFG_EE_SSID    6'h01
`endif

// ---- hw/pcfg_pkg.sv ----
// Types of the configuration header block
package pcfg_pkg;
    // ==========================================
    // Whole register state of the block
    typedef struct packed {
        logic [1:0]  strap_sync;
        logic        strap_done;
        logic        multifunc;
        logic        serr_en;
        logic        perr_en;
        logic        bm_en;
        logic        mem_en;
        logic        io_en;
        logic        dpe;
        logic        sse;
        logic        rma;
        logic        rta;
        logic        mdpe;
        logic [7:0]  lat_timer;
        logic [7:0]  lat_count;
        logic [7:0]  int_line;
        logic [24:0] io_base;
        logic [24:0] mem_base;
        logic [13:0] rom_base;
        logic        rom_en;
        logic [15:0] ssid;
        logic [15:0] ssvid;
        logic [31:0] rdata;
        logic        rvalid;
        logic        devsel_pipe;
        logic        devsel_n;
        logic        serr_n;
        logic        perr_n;
        logic        io_hit;
        logic        mem_hit;
        logic        rom_hit;
        logic        mst_stop;
    } pcfg_state_t;
endpackage

// ---- hw/pcfg_config_space.sv ----
// Type-0 configuration header with parity, abort and decode logic
`timescale 1ns/1ps
`include "pcfg_defs.svh"
// Overview of operation
// R1: Parity error sets bit 31; one clears
// R2: Check address, target IRDY&TRDY, master read phases
// R3: SERR only with bits 8,6; sets 30
// R4: Master abort sets bit 29, one clears
// R5: Received target abort sets bit 28
// R6: Never target-abort; bit 27 reads zero
// R7: Medium timing 01; DEVSEL two clocks later
// R8: Bit 24 only as master, response enabled
// R9: Status bit 20 reads one
// R10: Fast back-to-back bit 9 reads zero
// R11: Bit 6 gates PERR and SERR reporting
// R12: Master cycles only with bit 2, default one
// R13: Memory and ROM cycles need bit 1
// R14: I/O cycles need bit 0
// R15: Class code 020000 in bits 31:8
// R16: Header 00, or 80 with strap high
// R17: Latency timer counts down from master FRAME
// R18: I/O base compares 31:7, bit0 one
// R19: Memory base compares 31:7, bit0 zero
// R20: Subsystem IDs loaded from EEPROM words 0,1
// R21: ROM bits 17:1 zero; needs enable bits
// R22: Fixed 28, 14, 01; writable line
// R23: Byte-lane writes; unmapped reads zero
// R24: Host reaches registers via IDSEL config cycles
module pcfg_config_space #(
    parameter logic [15:0] DEVICE_ID = 16'hA5A5, // Arbitrary value
    parameter logic [15:0] VENDOR_ID = 16'h5A5A, // Arbitrary value
    parameter logic [7:0]  REVISION  = 8'h11     // Arbitrary value
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        CFG_IDSEL,
    input  wire logic        CFG_RD,
    input  wire logic        CFG_WR,
    input  wire logic [7:0]  CFG_ADDR,
    input  wire logic [3:0]  CFG_BE_N,
    input  wire logic [31:0] CFG_WDATA,
    output logic      [31:0] CFG_RDATA,
    output logic             CFG_RVALID,
    input  wire logic        DEC_VALID,
    input  wire logic        DEC_IO,
    input  wire logic [31:0] DEC_ADDR,
    output logic             IO_HIT,
    output logic             MEM_HIT,
    output logic             ROM_HIT,
    input  wire logic        TGT_FRAME,
    output logic             DEVSEL_N,
    input  wire logic [31:0] CHK_AD,
    input  wire logic [3:0]  CHK_CBE_N,
    input  wire logic        CHK_PAR,
    input  wire logic        CHK_ADDR_PH,
    input  wire logic        CHK_TGT_PH,
    input  wire logic        IRDY_N,
    input  wire logic        TRDY_N,
    input  wire logic        CHK_MST_RD,
    input  wire logic        MST_ACTIVE,
    input  wire logic        MST_WR_PERR,
    input  wire logic        MST_ABORT,
    input  wire logic        MST_TGT_ABORT,
    input  wire logic        MST_FRAME_START,
    input  wire logic        GNT_N,
    output logic             MST_STOP,
    output logic             BM_EN,
    output logic             SERR_N,
    output logic             PERR_N,
    input  wire logic        EE_WR,
    input  wire logic [5:0]  EE_ADDR,
    input  wire logic [15:0] EE_DATA,
    input  wire logic        MF_STRAP
);

    pcfg_pkg::pcfg_state_t q;
    pcfg_pkg::pcfg_state_t next_q;

    // ==========================================
    // Helpers
    function automatic logic [31:0] lane_mask(input logic [3:0] be_n);
        lane_mask = {{8{~be_n[3]}}, {8{~be_n[2]}}, {8{~be_n[1]}}, {8{~be_n[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    // ==========================================
    // Read view of each register
    function automatic logic [31:0] read_word(input pcfg_pkg::pcfg_state_t s,
                                              input logic [7:0] a);
        read_word = 32'h0000_0000; // [R23]
        unique case ({a[7:2], 2'b00})
            `PCFG_OFF_ID:    read_word = {DEVICE_ID, VENDOR_ID};
            `PCFG_OFF_CMD:   read_word = {s.dpe, s.sse, s.rma, s.rta, 1'b0, // [R6]
                                          `PCFG_DEVSEL_MED, s.mdpe, 3'h0, 1'b1, // [R7] [R9]
                                          10'h000, 1'b0, s.serr_en, 1'b0, // [R10]
                                          s.perr_en, 3'h0, s.bm_en, s.mem_en, s.io_en};
            `PCFG_OFF_CLASS: read_word = {`PCFG_CLASS, REVISION}; // [R15]
            `PCFG_OFF_MISC:  read_word = {8'h00, s.multifunc ? `PCFG_HDR_MULTI : `PCFG_HDR_SINGLE, // [R16]
                                          s.lat_timer, 8'h00};
            `PCFG_OFF_IO:    read_word = {s.io_base, 6'h00, 1'b1}; // [R18]
            `PCFG_OFF_MEM:   read_word = {s.mem_base, 7'h00}; // [R19]
            `PCFG_OFF_SUB:   read_word = {s.ssid, s.ssvid}; // [R20]
            `PCFG_OFF_ROM:   read_word = {s.rom_base, 17'h00000, s.rom_en}; // [R21]
            `PCFG_OFF_CAP:   read_word = {24'h000000, `PCFG_CAP_PTR};
            `PCFG_OFF_INT:   read_word = {`PCFG_MAX_LAT, `PCFG_MIN_GNT, `PCFG_INT_PIN, s.int_line}; // [R22]
            default:         read_word = 32'h0000_0000;
        endcase
    endfunction

    // ==========================================
    // Parity check, even over AD, C/BE# and PAR
    logic par_bad;
    logic addr_perr;
    logic tgt_perr;
    logic mst_perr;

    assign par_bad   = ^{CHK_AD, CHK_CBE_N, CHK_PAR};
    assign addr_perr = CHK_ADDR_PH && par_bad; // [R2]
    assign tgt_perr  = CHK_TGT_PH && !IRDY_N && !TRDY_N && par_bad; // [R2]
    assign mst_perr  = CHK_MST_RD && par_bad; // [R2]

    // ==========================================
    // Next state
    logic        wr;
    logic [31:0] m;
    logic [31:0] clr;
    logic        serr_fire;
    logic [31:0] io_w;
    logic [31:0] mem_w;
    logic [31:0] rom_w;

    always_comb begin
        next_q = q;
        wr = CFG_WR && CFG_IDSEL; // [R24]
        m = lane_mask(CFG_BE_N); // [R23]
        clr = (wr && {CFG_ADDR[7:2], 2'b00} == `PCFG_OFF_CMD) ? (CFG_WDATA & m) : 32'h0000_0000;
        serr_fire = addr_perr && q.serr_en && q.perr_en; // [R3] [R11]
        io_w = merge({q.io_base, 7'h00}, CFG_WDATA, m);
        mem_w = merge({q.mem_base, 7'h00}, CFG_WDATA, m);
        rom_w = merge({q.rom_base, 18'h00000}, CFG_WDATA, m);

        // Strap is synchronised, then caught once after reset release
        next_q.strap_sync = {q.strap_sync[0], MF_STRAP};
        if (!q.strap_done) begin
            next_q.multifunc = q.strap_sync[1]; // [R16]
            next_q.strap_done = 1'b1;
        end

        // Register writes, byte lane by byte lane
        if (wr) begin
            unique case ({CFG_ADDR[7:2], 2'b00})
                `PCFG_OFF_CMD: begin
                    if (m[`PCFG_CMD_SERR]) next_q.serr_en = CFG_WDATA[`PCFG_CMD_SERR];
                    if (m[`PCFG_CMD_PERR]) next_q.perr_en = CFG_WDATA[`PCFG_CMD_PERR];
                    if (m[`PCFG_CMD_BM])   next_q.bm_en = CFG_WDATA[`PCFG_CMD_BM];
                    if (m[`PCFG_CMD_MEM])  next_q.mem_en = CFG_WDATA[`PCFG_CMD_MEM];
                    if (m[`PCFG_CMD_IO])   next_q.io_en = CFG_WDATA[`PCFG_CMD_IO];
                end
                `PCFG_OFF_MISC: if (m[8]) next_q.lat_timer = CFG_WDATA[15:8];
                `PCFG_OFF_IO:   next_q.io_base = io_w[31:7];
                `PCFG_OFF_MEM:  next_q.mem_base = mem_w[31:7];
                `PCFG_OFF_ROM: begin
                    next_q.rom_base = rom_w[31:18];
                    if (m[0]) next_q.rom_en = CFG_WDATA[0];
                end
                `PCFG_OFF_INT:  if (m[0]) next_q.int_line = CFG_WDATA[7:0];
                default: ;
            endcase
        end

        // Sticky status: a set in the clearing cycle wins
        next_q.dpe = (addr_perr || tgt_perr || mst_perr) || (q.dpe && !clr[`PCFG_STS_DPE]); // [R1]
        next_q.sse = serr_fire || (q.sse && !clr[`PCFG_STS_SSE]); // [R3]
        next_q.rma = MST_ABORT || (q.rma && !clr[`PCFG_STS_RMA]); // [R4]
        next_q.rta = MST_TGT_ABORT || (q.rta && !clr[`PCFG_STS_RTA]); // [R5]
        next_q.mdpe = (MST_ACTIVE && q.perr_en && (mst_perr || MST_WR_PERR)) // [R8]
                      || (q.mdpe && !clr[`PCFG_STS_MDPE]);

        // Error pins, one cycle low per event
        next_q.serr_n = !serr_fire; // [R3]
        next_q.perr_n = !(q.perr_en && (tgt_perr || mst_perr)); // [R11]

        // Config read answer, full dword regardless of byte enables
        next_q.rvalid = CFG_RD && CFG_IDSEL; // [R24]
        if (CFG_RD && CFG_IDSEL) next_q.rdata = read_word(q, CFG_ADDR); // [R23]

        // Address decode of the two BARs and the ROM window
        next_q.io_hit = DEC_VALID && DEC_IO && q.io_en && // [R14]
                        DEC_ADDR[31:`PCFG_BAR_LSB] == q.io_base; // [R18]
        next_q.mem_hit = DEC_VALID && !DEC_IO && q.mem_en && // [R13]
                         DEC_ADDR[31:`PCFG_BAR_LSB] == q.mem_base; // [R19]
        next_q.rom_hit = DEC_VALID && !DEC_IO && q.mem_en && q.rom_en && // [R21]
                         DEC_ADDR[31:`PCFG_ROM_LSB] == q.rom_base;

        // Medium DEVSEL timing: a two-stage delay
        next_q.devsel_pipe = TGT_FRAME; // [R7]
        next_q.devsel_n = !q.devsel_pipe; // [R7]

        // Latency timer; a start without bus-master enable is ignored
        if (MST_FRAME_START && q.bm_en) begin // [R12]
            next_q.lat_count = q.lat_timer; // [R17]
        end else if (MST_ACTIVE && q.lat_count != 8'h00) begin
            next_q.lat_count = q.lat_count - 8'h01; // [R17]
        end
        // Grant lost while count non-zero keeps the burst going
        next_q.mst_stop = MST_ACTIVE && !MST_FRAME_START && q.lat_count == 8'h00 && GNT_N; // [R17]

        // EEPROM words 0 and 1 carry the subsystem identity
        if (EE_WR && EE_ADDR == `PCFG_EE_SSVID) next_q.ssvid = EE_DATA; // [R20]
        if (EE_WR && EE_ADDR == `PCFG_EE_SSID)  next_q.ssid = EE_DATA; // [R20]
    end

    // ==========================================
    // State register
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            q <= '0;
            // Synchroniser keeps running so the strap is valid at release
            q.strap_sync <= {q.strap_sync[0], MF_STRAP};
            q.bm_en <= `PCFG_RST_CMDEN; // [R12]
            q.mem_en <= `PCFG_RST_CMDEN;
            q.io_en <= `PCFG_RST_CMDEN;
            q.devsel_n <= 1'b1;
            q.serr_n <= 1'b1;
            q.perr_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // ==========================================
    // Outputs, all straight from flops
    assign CFG_RDATA  = q.rdata;
    assign CFG_RVALID = q.rvalid;
    assign IO_HIT     = q.io_hit;
    assign MEM_HIT    = q.mem_hit;
    assign ROM_HIT    = q.rom_hit;
    assign DEVSEL_N   = q.devsel_n;
    assign MST_STOP   = q.mst_stop;
    assign BM_EN      = q.bm_en;
    assign SERR_N     = q.serr_n;
    assign PERR_N     = q.perr_n;

    // ==========================================
    // Assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    property p_dpe_set;
        (addr_perr || tgt_perr || mst_perr) |=> q.dpe;
    endproperty
    a_dpe_set: assert property (p_dpe_set) else $error("parity error not recorded"); // [R1]

    property p_serr_gate;
        addr_perr |=> (SERR_N == !($past(q.serr_en) && $past(q.perr_en))) && (SERR_N || q.sse);
    endproperty
    a_serr_gate: assert property (p_serr_gate) else $error("SERR gating wrong"); // [R3]

    property p_rma;
        MST_ABORT |=> q.rma;
    endproperty
    a_rma: assert property (p_rma) else $error("master abort not recorded"); // [R4]

    property p_rta;
        MST_TGT_ABORT |=> q.rta;
    endproperty
    a_rta: assert property (p_rta) else $error("target abort not recorded"); // [R5]

    property p_fixed_bits;
        CFG_RVALID && $past(CFG_ADDR[7:2]) == 6'h01 |-> !CFG_RDATA[27] && !CFG_RDATA[9]
            && CFG_RDATA[20] && CFG_RDATA[26:25] == 2'b01;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits wrong"); // [R6]

    property p_devsel;
        TGT_FRAME |-> DEVSEL_N ##2 !DEVSEL_N;
    endproperty
    a_devsel: assert property (p_devsel) else $error("DEVSEL not two clocks late"); // [R7]

    property p_mdpe;
        $rose(q.mdpe) |-> $past(MST_ACTIVE) && $past(q.perr_en);
    endproperty
    a_mdpe: assert property (p_mdpe) else $error("bit 24 set outside master"); // [R8]

    property p_perr_off;
        !q.perr_en && (tgt_perr || mst_perr) |=> PERR_N;
    endproperty
    a_perr_off: assert property (p_perr_off) else $error("PERR driven while disabled"); // [R11]

    property p_mem_off;
        !q.mem_en |=> !MEM_HIT && !ROM_HIT;
    endproperty
    a_mem_off: assert property (p_mem_off) else $error("memory hit while disabled"); // [R13]

    property p_io_off;
        !q.io_en |=> !IO_HIT;
    endproperty
    a_io_off: assert property (p_io_off) else $error("I/O hit while disabled"); // [R14]

    property p_lat;
        MST_ACTIVE && !MST_FRAME_START && q.lat_count != 8'h00 |=> !MST_STOP;
    endproperty
    a_lat: assert property (p_lat) else $error("stop before latency expiry"); // [R17]

    property p_dpe_clr;
        clr[31] && !addr_perr && !tgt_perr && !mst_perr |=> !q.dpe;
    endproperty
    a_dpe_clr: assert property (p_dpe_clr) else $error("bit 31 not cleared"); // [R1]

    property p_sse_pin;
        $rose(q.sse) |-> !SERR_N;
    endproperty
    a_sse_pin: assert property (p_sse_pin) else $error("bit 30 set without SERR"); // [R3]

    property p_rma_clr;
        clr[29] && !MST_ABORT |=> !q.rma;
    endproperty
    a_rma_clr: assert property (p_rma_clr) else $error("bit 29 not cleared"); // [R4]

    property p_mdpe_set;
        MST_ACTIVE && q.perr_en && (mst_perr || MST_WR_PERR) |=> q.mdpe;
    endproperty
    a_mdpe_set: assert property (p_mdpe_set) else $error("bit 24 not set"); // [R8]

    property p_perr_on;
        q.perr_en && (tgt_perr || mst_perr) |=> !PERR_N;
    endproperty
    a_perr_on: assert property (p_perr_on) else $error("PERR not driven"); // [R11]

    property p_lat_load;
        MST_FRAME_START && q.bm_en |=> q.lat_count == $past(q.lat_timer);
    endproperty
    a_lat_load: assert property (p_lat_load) else $error("latency count not loaded"); // [R17]

    property p_lat_stop;
        MST_ACTIVE && !MST_FRAME_START && q.lat_count == 8'h00 && GNT_N |=> MST_STOP;
    endproperty
    a_lat_stop: assert property (p_lat_stop) else $error("no stop after expiry"); // [R17]

    property p_io_hit;
        IO_HIT |-> $past(DEC_VALID) && $past(DEC_IO) && $past(q.io_en);
    endproperty
    a_io_hit: assert property (p_io_hit) else $error("I/O hit without request"); // [R14]

    property p_rom_hit;
        ROM_HIT |-> $past(q.mem_en) && $past(q.rom_en) && !$past(DEC_IO);
    endproperty
    a_rom_hit: assert property (p_rom_hit) else $error("ROM hit while disabled"); // [R21]

    property p_devsel_src;
        !DEVSEL_N |-> $past(TGT_FRAME, 2);
    endproperty
    a_devsel_src: assert property (p_devsel_src) else $error("DEVSEL without FRAME"); // [R7]

    property p_class;
        CFG_RVALID && $past(CFG_ADDR[7:2]) == 6'h02 |-> CFG_RDATA[31:8] == `PCFG_CLASS;
    endproperty
    a_class: assert property (p_class) else $error("class code wrong"); // [R15]

    property p_int_fixed;
        CFG_RVALID && $past(CFG_ADDR[7:2]) == 6'h0F |->
            CFG_RDATA[31:8] == {`PCFG_MAX_LAT, `PCFG_MIN_GNT, `PCFG_INT_PIN};
    endproperty
    a_int_fixed: assert property (p_int_fixed) else $error("fixed latency bytes wrong"); // [R22]

    property p_io_low;
        CFG_RVALID && $past(CFG_ADDR[7:2]) == 6'h04 |-> CFG_RDATA[6:0] == 7'h01;
    endproperty
    a_io_low: assert property (p_io_low) else $error("I/O base low bits wrong"); // [R18]

endmodule // pcfg_config_space

// ---- verification/pcfg_host_model.sv ----
// Host bridge model issuing configuration cycles
`timescale 1ns/1ps
module pcfg_host_model (
    input  logic        clk,
    input  logic [31:0] rdata,
    input  logic        rvalid,
    output logic        idsel,
    output logic        rd,
    output logic        wr,
    output logic [7:0]  addr,
    output logic [3:0]  be_n,
    output logic [31:0] wdata
);
    // ==========================================
    // Idle bus
    initial begin
        idsel = 1'b0;
        rd    = 1'b0;
        wr    = 1'b0;
        addr  = 8'h00;
        be_n  = 4'hF;
        wdata = 32'h00000000;
    end
    // ==========================================
    // Configuration cycles, launched at the falling edge
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(negedge clk);
        idsel = 1'b1;
        wr    = 1'b1;
        addr  = a;
        be_n  = b;
        wdata = d;
        @(negedge clk);
        idsel = 1'b0;
        wr    = 1'b0;
        be_n  = 4'hF;
        // Released lines flip so stale values cannot pass
        addr  = ~a;
        wdata = ~d;
    endtask
    task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk);
        idsel = 1'b1;
        rd    = 1'b1;
        addr  = a;
        @(negedge clk);
        idsel = 1'b0;
        rd    = 1'b0;
        addr  = ~a;
        // Answer only counts in its one valid cycle
        d = (rvalid === 1'b1) ? rdata : 'x;
    endtask
endmodule // pcfg_host_model

// ---- verification/tb.sv ----
// Self-checking bench of the configuration header block
`timescale 1ns/1ps
`include "pcfg_defs.svh"
module tb;
    // ==========================================
    // Signals
    localparam logic [15:0] DEV_ID = 16'h3C3C; // Arbitrary value
    localparam logic [15:0] VEN_ID = 16'hC3C3; // Arbitrary value
    localparam logic [7:0]  REV_ID = 8'h42;    // Arbitrary value
    logic        clk = 1'b0, rst_n = 1'b0, dv = 1'b0, dio = 1'b0, tf = 1'b0, par = 1'b1;
    logic        aph = 1'b0, tph = 1'b0, mrd = 1'b0, irdy_n = 1'b0, trdy_n = 1'b1, mact = 1'b0;
    logic        mwperr = 1'b0, mab = 1'b0, mtab = 1'b0, mfs = 1'b0, gnt_n = 1'b0, ee_wr = 1'b0;
    logic        strap = 1'b0, idsel, rd, wr, rvalid, io_hit, mem_hit, rom_hit, devsel_n;
    logic        stop, bm_en, serr_n, perr_n;
    logic [7:0]  addr;
    logic [3:0]  be_n;
    logic [5:0]  ee_addr = 6'h00;
    logic [15:0] ee_data = 16'h0000;
    logic [31:0] wdata, rdata, rv, dec_addr = 32'h00000000;
    int          err_total = 0, num_checks = 0, cycles = 0;
    logic [7:0]  ra [12] = '{`PCFG_OFF_ID, `PCFG_OFF_CMD, `PCFG_OFF_CLASS, `PCFG_OFF_MISC, `PCFG_OFF_IO,
        `PCFG_OFF_MEM, `PCFG_OFF_SUB, `PCFG_OFF_ROM, `PCFG_OFF_CAP, `PCFG_OFF_INT, 8'h18, 8'h40};
    logic [31:0] rx [12] = '{{DEV_ID, VEN_ID}, 32'h02100007, {24'h020000, REV_ID}, 32'h0, 32'h1, 32'h0,
        32'h0, 32'h0, 32'h50, 32'h28140100, 32'h0, 32'h0};
    logic [31:0] wx [12] = '{{DEV_ID, VEN_ID}, 32'h02100147, {24'h020000, REV_ID}, 32'h0000FF00,
        32'hFFFFFF81, 32'hFFFFFF80, 32'h0, 32'hFFFC0001, 32'h50, 32'h281401FF, 32'h0, 32'h0};
    // ==========================================
    // Design and host
    pcfg_config_space #(.DEVICE_ID(DEV_ID), .VENDOR_ID(VEN_ID), .REVISION(REV_ID)) u_pcfg_config_space (
        .CLK(clk), .RESET_N(rst_n), .CFG_IDSEL(idsel), .CFG_RD(rd), .CFG_WR(wr), .CFG_ADDR(addr),
        .CFG_BE_N(be_n), .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .DEC_VALID(dv),
        .DEC_IO(dio), .DEC_ADDR(dec_addr), .IO_HIT(io_hit), .MEM_HIT(mem_hit), .ROM_HIT(rom_hit),
        .TGT_FRAME(tf), .DEVSEL_N(devsel_n), .CHK_AD(32'h00000001), .CHK_CBE_N(4'h0), .CHK_PAR(par),
        .CHK_ADDR_PH(aph), .CHK_TGT_PH(tph), .IRDY_N(irdy_n), .TRDY_N(trdy_n), .CHK_MST_RD(mrd),
        .MST_ACTIVE(mact), .MST_WR_PERR(mwperr), .MST_ABORT(mab), .MST_TGT_ABORT(mtab),
        .MST_FRAME_START(mfs), .GNT_N(gnt_n), .MST_STOP(stop), .BM_EN(bm_en), .SERR_N(serr_n),
        .PERR_N(perr_n), .EE_WR(ee_wr), .EE_ADDR(ee_addr), .EE_DATA(ee_data), .MF_STRAP(strap));
    pcfg_host_model u_pcfg_host_model (.clk(clk), .rdata(rdata), .rvalid(rvalid), .idsel(idsel), .rd(rd),
        .wr(wr), .addr(addr), .be_n(be_n), .wdata(wdata));
    always #50 clk = ~clk;
    // ==========================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        u_pcfg_host_model.cfg_rd(a, rv);
        chk(rv, exp);
    endtask
    task automatic wrr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        u_pcfg_host_model.cfg_wr(a, b, d);
    endtask
    // Hits checked in the one cycle they stand
    task automatic dec(input logic io, input logic [31:0] a, input logic [2:0] exp);
        @(negedge clk);
        dv = 1'b1;
        dio = io;
        dec_addr = a;
        @(negedge clk);
        dv = 1'b0;
        dec_addr = ~a;
        chk({29'h0, io_hit, mem_hit, rom_hit}, {29'h0, exp});
    endtask
    // Bad parity in the phase kinds given as {address, target, master read}
    task automatic par_err(input logic [2:0] ph, input logic [1:0] exp);
        @(negedge clk);
        {aph, tph, mrd} = ph;
        par = 1'b0;
        @(negedge clk);
        {aph, tph, mrd} = 3'b000;
        par = 1'b1;
        chk({30'h0, serr_n, perr_n}, {30'h0, exp});
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========================================
    // Hang guard, well above the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            print_verdict();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        tick(20);
        rst_n = 1'b1;
        chk({31'h0, bm_en}, 32'h1);
        foreach (ra[i]) rdchk(ra[i], rx[i]);
        foreach (ra[i]) begin
            wrr(ra[i], 4'h0, 32'hFFFFFFFF);
            rdchk(ra[i], wx[i]);
        end
        wrr(`PCFG_OFF_INT, 4'hE, 32'h0000005A);
        rdchk(`PCFG_OFF_INT, 32'h2814015A);
        wrr(`PCFG_OFF_MISC, 4'hD, 32'h00000300);
        rdchk(`PCFG_OFF_MISC, 32'h00000300);
        // Master burst: grant gone early, then count expires under grant
        mfs = 1'b1;
        mact = 1'b1;
        gnt_n = 1'b1;
        tick(1);
        mfs = 1'b0;
        tick(1);
        chk({31'h0, stop}, 32'h0);
        tick(6);
        chk({31'h0, stop}, 32'h1);
        mact = 1'b0;
        gnt_n = 1'b0;
        tick(1);
        mfs = 1'b1;
        mact = 1'b1;
        tick(1);
        mfs = 1'b0;
        tick(8);
        chk({31'h0, stop}, 32'h0);
        gnt_n = 1'b1;
        tick(2);
        chk({31'h0, stop}, 32'h1);
        mact = 1'b0;
        // Parity reporting and status clearing
        par_err(3'b100, 2'b01);
        rdchk(`PCFG_OFF_CMD, 32'hC2100147);
        wrr(`PCFG_OFF_CMD, 4'h7, 32'h80000000);
        rdchk(`PCFG_OFF_CMD, 32'h42100147);
        par_err(3'b010, 2'b11);
        trdy_n = 1'b0;
        par_err(3'b010, 2'b10);
        wrr(`PCFG_OFF_CMD, 4'h7, 32'hFF000000);
        wrr(`PCFG_OFF_CMD, 4'hE, 32'h00000007);
        par_err(3'b100, 2'b11);
        mact = 1'b1;
        mwperr = 1'b1;
        tick(1);
        mwperr = 1'b0;
        rdchk(`PCFG_OFF_CMD, 32'h82100107);
        wrr(`PCFG_OFF_CMD, 4'hE, 32'h00000047);
        par_err(3'b001, 2'b10);
        mab = 1'b1;
        tick(1);
        mab = 1'b0;
        mtab = 1'b1;
        tick(1);
        mtab = 1'b0;
        rdchk(`PCFG_OFF_CMD, 32'hB3100147);
        wrr(`PCFG_OFF_CMD, 4'h7, 32'hFF000000);
        rdchk(`PCFG_OFF_CMD, 32'h02100147);
        mact = 1'b0;
        // Target select timing
        tf = 1'b1;
        tick(1);
        tf = 1'b0;
        chk({31'h0, devsel_n}, 32'h1);
        tick(1);
        chk({31'h0, devsel_n}, 32'h0);
        tick(1);
        chk({31'h0, devsel_n}, 32'h1);
        // Address decode with every enable combination of interest
        wrr(`PCFG_OFF_IO, 4'h0, 32'h12345680);
        wrr(`PCFG_OFF_MEM, 4'h0, 32'hABCDEF00);
        wrr(`PCFG_OFF_ROM, 4'h0, 32'h55540001);
        dec(1'b1, 32'h123456FF, 3'b100);
        dec(1'b1, 32'h1234567F, 3'b000);
        dec(1'b0, 32'hABCDEF7C, 3'b010);
        dec(1'b0, 32'hABCDEF80, 3'b000);
        dec(1'b0, 32'h5557FFFC, 3'b001);
        dec(1'b0, 32'h55580000, 3'b000);
        wrr(`PCFG_OFF_CMD, 4'hE, 32'h00000044);
        dec(1'b1, 32'h123456FF, 3'b000);
        dec(1'b0, 32'hABCDEF7C, 3'b000);
        dec(1'b0, 32'h5557FFFC, 3'b000);
        wrr(`PCFG_OFF_CMD, 4'hE, 32'h00000003);
        chk({31'h0, bm_en}, 32'h0);
        wrr(`PCFG_OFF_ROM, 4'hE, 32'h00000000);
        dec(1'b0, 32'h5557FFFC, 3'b000);
        dec(1'b0, 32'hABCDEF7C, 3'b010);
        // Subsystem words, back to back
        ee_wr = 1'b1;
        ee_data = 16'hBEEF;
        tick(1);
        ee_addr = 6'h01;
        ee_data = 16'hCAFE;
        tick(1);
        ee_wr = 1'b0;
        rdchk(`PCFG_OFF_SUB, 32'hCAFEBEEF);
        // Strap only counts when sampled out of reset
        strap = 1'b1;
        rst_n = 1'b0;
        tick(4);
        rst_n = 1'b1;
        rdchk(`PCFG_OFF_MISC, 32'h00800000);
        print_verdict();
    end
endmodule // tb
